// [hdl/io_sync_timer_defs.vh]
/*
  Constants shared by the input conditioning and timer/counter block:
  clock rates, sampling divider, timer tick, gate time and mode codes.
  Assumes clk runs at CLK_MHZ and stands in for the crystal input clock.
*/
`ifndef IO_SYNC_TIMER_DEFS_VH
`define IO_SYNC_TIMER_DEFS_VH

// Clock rate and pin synchroniser sampling divider.
`define CLK_MHZ          100
`define SYNC_DIV         2

// Timer base tick and level latch period, in nanoseconds.
`define TICK_NS          200
`define TICK_CYCLES      ((`TICK_NS * `CLK_MHZ + 999) / 1000)

// Edge counting gate interval, in milliseconds.
`define GATE_MS          839
`define GATE_CYCLES      (`GATE_MS * 1000 * `CLK_MHZ)

// Quadrature saturation limits.
`define QUAD_MAX         16'h3FFF
`define QUAD_MIN         16'hC001

// Counter saturation value.
`define CNT_MAX          16'hFFFF

// Timer/counter mode codes.
`define MODE_IDLE        4'h0
`define MODE_ONTIME      4'h1
`define MODE_PERIOD      4'h2
`define MODE_PULSECOUNT  4'h3
`define MODE_TOTALCOUNT  4'h4
`define MODE_QUAD        4'h5
`define MODE_EDGELOG     4'h6
`define MODE_FREQ        4'h8
`define MODE_ONESHOT     4'h9
`define MODE_PWM         4'hA
`define MODE_EDGEDIV     4'hB
`define MODE_TRIAC       4'hC
`define MODE_TRIGCOUNT   4'hD

`endif

// [hdl/sync_bank.v]
/*
  A bank of two-stage synchronisers with a common sample enable.
  Assumes the inputs are asynchronous to clk and the enable is a
  one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_bank #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Sampling
  input  wire             sampleEn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds only the second one, so metastability has a full
  // sample period to settle before anything else sees the level.
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else if (sampleEn) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

`default_nettype wire

// [hdl/io_sync_timer.v]
/*
  Input conditioning for a twelve pin I/O port and two 16-bit timer/counters
  with their measurement and generation functions.
  Assumes clk is the crystal input clock, all pins are asynchronous, and the
  CPU byte port is driven from logic on clk.
*/
// What this block does
// - Each input pin passes a hardware synchroniser before any logic reads it.
// - Synchroniser samples at the input clock divided by two.
// - Chip select rising edges are seen without the slow synchroniser.
// - Level detect latches a falling edge on a 200 ns clock until cleared.
// - Serial receive data is buffered per byte and raises an interrupt.
// - Timer input results land in a readable latch without CPU help.
// - Pulse width and period measure 0.2 us up to 1.678 s.
// - Edge counting over a 0.839 s gate reports 0 to 65535 edges.
// - Quadrature decoding keeps a signed count within plus or minus 16383.
// - Edge logging records the time between successive transitions.
// - Square wave output spans 0.3 Hz to 2.5 MHz.
// - One pulse output lasts from 0.2 us to 1.678 s.
// - Pulse train duty cycle is settable from zero to full.
// - Edge divider outputs the input frequency divided by a chosen divisor.
// - Phase delay emits a pulse a programmed time after each input edge.
// - Triggered count output ends after a programmed number of edges.
// - Each timer has byte-written load, counter and byte-read latch.
// - First timer input is muxed from four pins, second is fixed.
// - Timer input edges act on rising, falling or both edges.
`timescale 1ns/1ps
`default_nettype none
`include "io_sync_timer_defs.vh"

module io_sync_timer #(
  parameter GATE_CYCLES = `GATE_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Pins
  input  wire [11:0] pinIn,
  input  wire        chipSelectPin,
  output wire [11:0] syncPins,
  output wire [1:0]  tmrOut,
  // Level detect
  input  wire [7:0]  levelClear,
  output reg  [7:0]  levelLatched,
  // Chip select
  output reg         chipSelectRise,
  // Serial receive byte buffer
  input  wire        rxAck,
  output reg  [7:0]  rxByte,
  output reg         rxIrq,
  // Timer configuration
  input  wire [7:0]  tmrMode,
  input  wire [3:0]  tmrEdgeSel,
  input  wire [5:0]  tmrClkSel,
  input  wire [1:0]  tmr1PinSel,
  // CPU byte port
  input  wire        cpuWrEn,
  input  wire        cpuTmr,
  input  wire        cpuHiByte,
  input  wire [7:0]  cpuData,
  input  wire        cpuRdTmr,
  input  wire        cpuRdHi,
  output reg  [7:0]  latchByte,
  output wire [1:0]  measDone
);

  localparam [31:0] TICK_LAST_W = `TICK_CYCLES - 1;
  localparam [31:0] SYNC_LAST_W = `SYNC_DIV - 1;
  localparam [31:0] GATE_LAST_W = GATE_CYCLES - 1;
  localparam [7:0]  TICK_LAST   = TICK_LAST_W[7:0];
  localparam [3:0]  SYNC_LAST   = SYNC_LAST_W[3:0];
  localparam [26:0] GATE_LAST   = GATE_LAST_W[26:0];

  reg  [3:0]  divCnt;
  reg         sysTick;
  reg  [7:0]  tickCnt;
  reg         baseTick;
  reg  [6:0]  prescale;
  wire [10:0] fastPins;
  reg  [7:0]  levelPrev;
  reg         csPrev;
  reg         sclkPrev;
  reg  [2:0]  bitCnt;
  reg  [7:0]  shiftReg;
  wire [31:0] latchAll;
  wire [3:0]  hiPins;

  assign hiPins = syncPins[7:4];

  // True when the selected edge kind occurs between two samples.
  function edgeMatch;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
      edgeMatch = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    end
  endfunction

  // Timer tick: base tick scaled by two to the power of the clock select.
  function tickFor;
    input [2:0] sel;
    input [6:0] pre;
    input       base;
    reg   [6:0] mask;
    begin
      mask = ~(7'h7F << sel);
      tickFor = base & ((pre & mask) == mask);
    end
  endfunction

  // Gray code step: 2'b01 counts up, 2'b11 counts down, 2'b00 holds.
  function [1:0] quadStep;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: quadStep = 2'b01;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: quadStep = 2'b11;
        default: quadStep = 2'b00;
      endcase
    end
  endfunction

  // Sampling enable at half the input clock and the 200 ns base tick.
  always @(posedge clk) begin
    if (!rst_n) begin
      divCnt   <= 4'h0;
      sysTick  <= 1'b0;
      tickCnt  <= 8'h00;
      baseTick <= 1'b0;
      prescale <= 7'h00;
    end else begin
      sysTick  <= (divCnt == SYNC_LAST);
      divCnt   <= (divCnt == SYNC_LAST) ? 4'h0 : divCnt + 4'h1;
      baseTick <= (tickCnt == TICK_LAST);
      tickCnt  <= (tickCnt == TICK_LAST) ? 8'h00 : tickCnt + 8'h01;
      if (baseTick)
        prescale <= prescale + 7'h01;
    end
  end

  // Slow synchroniser for general pin use.
  sync_bank #(.WIDTH(12)) u_pinSync (
    .clk      (clk),
    .rst_n    (rst_n),
    .sampleEn (sysTick),
    .din      (pinIn),
    .dout     (syncPins)
  );

  // Full-rate synchroniser for the paths that bypass the slow one, so that
  // chip select edges and serial shift clock edges are not lost.
  sync_bank #(.WIDTH(11)) u_fastSync (
    .clk      (clk),
    .rst_n    (rst_n),
    .sampleEn (1'b1),
    .din      ({chipSelectPin, pinIn[9:0]}),
    .dout     (fastPins)
  );

  // Level detect, chip select edge and serial byte buffer.
  always @(posedge clk) begin
    if (!rst_n) begin
      // Starting low means a pin that idles low after reset is not taken for a fall.
      levelPrev      <= 8'h00;
      levelLatched   <= 8'h00;
      csPrev         <= 1'b0;
      chipSelectRise <= 1'b0;
      sclkPrev       <= 1'b0;
      bitCnt         <= 3'h0;
      shiftReg       <= 8'h00;
      rxByte         <= 8'h00;
      rxIrq          <= 1'b0;
    end else begin
      if (baseTick)
        levelPrev <= fastPins[7:0];
      // A falling edge in the clearing cycle still sets the latch.
      levelLatched <= (levelLatched & ~levelClear) |
                      (baseTick ? (levelPrev & ~fastPins[7:0]) : 8'h00);
      csPrev         <= fastPins[10];
      chipSelectRise <= fastPins[10] & ~csPrev;
      sclkPrev       <= fastPins[9];
      if (fastPins[9] & ~sclkPrev) begin
        shiftReg <= {shiftReg[6:0], fastPins[8]};
        bitCnt   <= bitCnt + 3'h1;
        if (bitCnt == 3'h7)
          rxByte <= {shiftReg[6:0], fastPins[8]};
      end
      rxIrq <= (rxIrq & ~rxAck) | (fastPins[9] & ~sclkPrev & (bitCnt == 3'h7));
    end
  end

  // Latch read port, one byte at a time.
  always @(posedge clk) begin
    if (!rst_n)
      latchByte <= 8'h00;
    else
      latchByte <= cpuRdTmr ? (cpuRdHi ? latchAll[31:24] : latchAll[23:16])
                            : (cpuRdHi ? latchAll[15:8] : latchAll[7:0]);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : tmr
      reg  [15:0] load;
      reg  [15:0] cnt;
      reg  [15:0] latch;
      reg  [3:0]  prevMode;
      reg         prevIn;
      reg  [1:0]  quadPrev;
      reg         outR;
      reg         running;
      reg         done;
      reg  [26:0] gateCnt;
      wire [3:0]  mode;
      wire [1:0]  edgeSel;
      wire        inSel;
      wire [1:0]  pair;
      wire        tick;
      wire        edgeHit;
      wire        wrHit;
      wire        arm;
      wire        gateEnd;
      wire [1:0]  step;
      wire [16:0] cntInc;
      wire        reachLoad;
      wire        notSat;

      assign mode      = tmrMode[4*g+3:4*g];
      assign edgeSel   = tmrEdgeSel[2*g+1:2*g];
      assign inSel     = (g == 0) ? hiPins[tmr1PinSel] : hiPins[0];
      assign pair      = (g == 0) ? hiPins[1:0] : hiPins[3:2];
      assign tick      = tickFor(tmrClkSel[3*g+2:3*g], prescale, baseTick);
      assign edgeHit   = edgeMatch(edgeSel, prevIn, inSel);
      assign wrHit     = cpuWrEn & (cpuTmr == g);
      assign arm       = wrHit & cpuHiByte;
      assign gateEnd   = (gateCnt == GATE_LAST);
      assign step      = quadStep(quadPrev, pair);
      assign cntInc    = {1'b0, cnt} + 17'h00001;
      assign reachLoad = cntInc >= {1'b0, load};
      assign notSat    = (cnt != `CNT_MAX);

      assign tmrOut[g]             = outR;
      assign measDone[g]           = done;
      assign latchAll[16*g+15:16*g] = latch;

      always @(posedge clk) begin
        if (!rst_n) begin
          load     <= 16'h0000;
          cnt      <= 16'h0000;
          latch    <= 16'h0000;
          prevMode <= 4'h0;
          prevIn   <= 1'b0;
          quadPrev <= 2'b00;
          outR     <= 1'b0;
          running  <= 1'b0;
          done     <= 1'b0;
          gateCnt  <= 27'h0000000;
        end else begin
          prevMode <= mode;
          prevIn   <= inSel;
          quadPrev <= pair;
          done     <= 1'b0;
          gateCnt  <= gateEnd ? 27'h0000000 : gateCnt + 27'h0000001;
          if (wrHit & ~cpuHiByte)
            load[7:0] <= cpuData;
          if (arm)
            load[15:8] <= cpuData;
          if (mode != prevMode) begin
            // A mode change restarts the counter so no stale count leaks out.
            cnt     <= 16'h0000;
            outR    <= 1'b0;
            running <= 1'b0;
          end else begin
            case (mode)
              `MODE_ONTIME: begin
                if (inSel) begin
                  if (tick & notSat)
                    cnt <= cntInc[15:0];
                end else if (prevIn) begin
                  latch <= cnt;
                  cnt   <= 16'h0000;
                  done  <= 1'b1;
                end
              end
              `MODE_PERIOD: begin
                if (edgeHit) begin
                  latch <= cnt;
                  cnt   <= 16'h0000;
                  done  <= 1'b1;
                end else if (tick & notSat)
                  cnt <= cntInc[15:0];
              end
              `MODE_PULSECOUNT: begin
                if (gateEnd) begin
                  latch <= cnt;
                  cnt   <= 16'h0000;
                  done  <= 1'b1;
                end else if (edgeHit & notSat)
                  cnt <= cntInc[15:0];
              end
              `MODE_TOTALCOUNT: begin
                if (edgeHit & notSat) begin
                  cnt   <= cntInc[15:0];
                  latch <= cntInc[15:0];
                  done  <= 1'b1;
                end
              end
              `MODE_QUAD: begin
                if (step == 2'b01 && cnt != `QUAD_MAX)
                  cnt <= cntInc[15:0];
                else if (step == 2'b11 && cnt != `QUAD_MIN)
                  cnt <= cnt - 16'h0001;
                latch <= cnt;
              end
              `MODE_EDGELOG: begin
                if (prevIn != inSel) begin
                  latch <= cnt;
                  cnt   <= 16'h0000;
                  done  <= 1'b1;
                end else if (tick & notSat)
                  cnt <= cntInc[15:0];
              end
              `MODE_FREQ: begin
                if (load == 16'h0000)
                  outR <= 1'b0;
                else if (tick) begin
                  // Half period is load ticks: load 1 gives 2.5 MHz.
                  if (reachLoad) begin
                    cnt  <= 16'h0000;
                    outR <= ~outR;
                  end else
                    cnt <= cntInc[15:0];
                end
              end
              `MODE_ONESHOT: begin
                if (arm) begin
                  outR <= 1'b1;
                  cnt  <= 16'h0000;
                end else if (outR & tick) begin
                  if (reachLoad) begin
                    outR <= 1'b0;
                    done <= 1'b1;
                  end else
                    cnt <= cntInc[15:0];
                end
              end
              `MODE_PWM: begin
                if (tick) begin
                  cnt  <= {8'h00, cntInc[7:0]};
                  outR <= load[8] | (cnt[7:0] < load[7:0]);
                end
              end
              `MODE_EDGEDIV: begin
                if (edgeHit & (load != 16'h0000)) begin
                  if (reachLoad) begin
                    cnt  <= 16'h0000;
                    outR <= ~outR;
                  end else
                    cnt <= cntInc[15:0];
                end
              end
              `MODE_TRIAC: begin
                if (edgeHit) begin
                  running <= 1'b1;
                  cnt     <= 16'h0000;
                  outR    <= 1'b0;
                end else if (tick) begin
                  if (running) begin
                    if (reachLoad) begin
                      running <= 1'b0;
                      outR    <= 1'b1;
                    end else
                      cnt <= cntInc[15:0];
                  end else
                    outR <= 1'b0;
                end
              end
              `MODE_TRIGCOUNT: begin
                if (arm) begin
                  outR <= 1'b1;
                  cnt  <= 16'h0000;
                end else if (outR & edgeHit) begin
                  if (reachLoad) begin
                    outR <= 1'b0;
                    done <= 1'b1;
                  end else
                    cnt <= cntInc[15:0];
                end
              end
              default: begin
                outR <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [bench/io_sync_timer_props.sv]
/*
  Port checker for io_sync_timer, bound to every instance of it.
  Assumes the pin source holds each level at least 22 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_sync_timer_defs.vh"

module io_sync_timer_props #(
  parameter GATE_CYCLES = 1000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Pins
  input wire logic [11:0] pinIn,
  input wire logic        chipSelectPin,
  input wire logic [11:0] syncPins,
  input wire logic [1:0]  tmrOut,
  // Events
  input wire logic [7:0]  levelClear,
  input wire logic [7:0]  levelLatched,
  input wire logic        chipSelectRise,
  input wire logic        rxAck,
  input wire logic        rxIrq,
  // Timers
  input wire logic [7:0]  tmrMode,
  input wire logic        cpuWrEn,
  input wire logic        cpuTmr,
  input wire logic        cpuHiByte,
  input wire logic [7:0]  cpuData,
  input wire logic [1:0]  measDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sync_follow: assert property ($stable(pinIn)[*8] |-> syncPins == pinIn)
    else $error("synced pins do not follow a steady pin");
  a_sync_rate: assert property ($changed(syncPins) |=> $stable(syncPins))
    else $error("synced pins changed on two clocks in a row");
  a_sync_lag: assert property ($changed(pinIn) |=>
    ((syncPins ^ $past(syncPins)) & ($past(pinIn) ^ $past(pinIn, 2))) == 12'h000)
    else $error("pin change passed in under two stages");
  a_cs_pulse: assert property ($rose(chipSelectPin) |-> ##[2:4] chipSelectRise)
    else $error("chip select rise not flagged");
  a_cs_single: assert property (chipSelectRise |=> !chipSelectRise)
    else $error("chip select flag longer than one clock");
  a_level_set: assert property ($fell(pinIn[0]) ##1 !pinIn[0] [*8] |->
    ##[1:24] levelLatched[0])
    else $error("low level not latched");
  a_level_hold: assert property (($past(levelLatched) & ~$past(levelClear)
    & ~levelLatched) == 8'h00)
    else $error("level latch lost without a clear");
  a_rx_hold: assert property (rxIrq && !rxAck |=> rxIrq)
    else $error("byte ready dropped without acknowledge");
  a_meas_pulse: assert property (|measDone |=> (measDone & $past(measDone)) == 2'b00)
    else $error("result strobe longer than one clock");
  a_oneshot_arm: assert property (cpuWrEn && !cpuTmr && cpuHiByte &&
    tmrMode[3:0] == `MODE_ONESHOT && cpuData != 8'h00 |-> ##[1:41] tmrOut[0])
    else $error("one pulse did not start");
endmodule

bind io_sync_timer io_sync_timer_props #(.GATE_CYCLES(GATE_CYCLES)) io_sync_timer_props_inst (
  .clk(clk), .rst_n(rst_n), .pinIn(pinIn), .chipSelectPin(chipSelectPin),
  .syncPins(syncPins), .tmrOut(tmrOut), .levelClear(levelClear),
  .levelLatched(levelLatched), .chipSelectRise(chipSelectRise), .rxAck(rxAck),
  .rxIrq(rxIrq), .tmrMode(tmrMode), .cpuWrEn(cpuWrEn), .cpuTmr(cpuTmr),
  .cpuHiByte(cpuHiByte), .cpuData(cpuData), .measDone(measDone));
`default_nettype wire

// [bench/pin_source.sv]
/*
  Behavioural stand-in for the sensors and logic that drive the pins.
  Assumes it shares clk with the block and is steered by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_source #(
  parameter int HOLD = 22
) (
  input  wire logic        clk,
  input  wire logic [11:0] want,
  output var  logic [11:0] pins
);
  int held = 0;

  initial pins = 12'h000;

  // An early request waits, so no level lasts less than HOLD clocks.
  always @(posedge clk) begin
    held <= held + 1;
    if (want != pins && held >= HOLD) begin
      pins <= #1 want;
      held <= 0;
    end
  end
endmodule
`default_nettype wire

// [bench/io_sync_timer_tb.sv]
/*
  Self-checking bench for io_sync_timer with a pin source model.
  Assumes a 100 MHz clock, so one 200 ns tick is 20 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_sync_timer_defs.vh"

module io_sync_timer_tb;
  localparam int T = 20;
  localparam int W = 256 * T;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] want = 12'h000;
  logic [11:0] pinIn;
  logic        chipSelectPin = 1'b0;
  logic [7:0]  levelClear = 8'h00;
  logic        rxAck = 1'b0;
  logic [7:0]  tmrMode = 8'h00;
  logic [3:0]  tmrEdgeSel = 4'h1;
  logic [5:0]  tmrClkSel = 6'h00;
  logic [1:0]  tmr1PinSel = 2'h0;
  logic        cpuWrEn = 1'b0;
  logic        cpuTmr = 1'b0;
  logic        cpuHiByte = 1'b0;
  logic [7:0]  cpuData = 8'h00;
  logic        cpuRdTmr = 1'b0;
  logic        cpuRdHi = 1'b0;
  wire  [11:0] syncPins;
  wire  [1:0]  tmrOut;
  wire  [7:0]  levelLatched;
  wire         chipSelectRise;
  wire  [7:0]  rxByte;
  wire         rxIrq;
  wire  [7:0]  latchByte;
  wire  [1:0]  measDone;
  int          i, s, e, k, n, m, p, cyc, n_errors, comparisons;
  logic [15:0] r, ld;
  logic [11:0] v;
  logic [7:0]  b;

  pin_source pin_source_inst (.clk(clk), .want(want), .pins(pinIn));

  io_sync_timer #(.GATE_CYCLES(1000)) io_sync_timer_inst (
    .clk(clk), .rst_n(rst_n), .pinIn(pinIn), .chipSelectPin(chipSelectPin),
    .syncPins(syncPins), .tmrOut(tmrOut), .levelClear(levelClear),
    .levelLatched(levelLatched), .chipSelectRise(chipSelectRise), .rxAck(rxAck),
    .rxByte(rxByte), .rxIrq(rxIrq), .tmrMode(tmrMode), .tmrEdgeSel(tmrEdgeSel),
    .tmrClkSel(tmrClkSel), .tmr1PinSel(tmr1PinSel), .cpuWrEn(cpuWrEn),
    .cpuTmr(cpuTmr), .cpuHiByte(cpuHiByte), .cpuData(cpuData), .cpuRdTmr(cpuRdTmr),
    .cpuRdHi(cpuRdHi), .latchByte(latchByte), .measDone(measDone));

  always #5 clk = ~clk;

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic drive(input logic [11:0] x);
    want = x;
    step(24);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr16(input logic t, input logic [15:0] x);
    cpuWrEn = 1'b1;
    cpuTmr = t;
    cpuHiByte = 1'b0;
    cpuData = x[7:0];
    step(1);
    cpuHiByte = 1'b1;
    cpuData = x[15:8];
    step(1);
    cpuWrEn = 1'b0;
    step(1);
  endtask

  task automatic rdLatch(input logic t, output logic [15:0] x);
    cpuRdTmr = t;
    cpuRdHi = 1'b0;
    step(2);
    x[7:0] = latchByte;
    cpuRdHi = 1'b1;
    step(2);
    x[15:8] = latchByte;
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(38141));
    step(6);
    rst_n = 1'b1;
    step(2);
    // Serial byte, most significant bit first, on shift clock rises.
    b = 8'($urandom);
    for (i = 7; i >= 0; i--) begin
      drive({3'b000, b[i], 8'h00});
      drive({3'b001, b[i], 8'h00});
    end
    check(rxIrq, 16'h0001);
    check(rxByte, b);
    check(levelLatched, 16'h0000);
    rxAck = 1'b1;
    step(1);
    rxAck = 1'b0;
    step(1);
    check(rxIrq, 16'h0000);
    chipSelectPin = 1'b1;
    n = 0;
    repeat (8) begin
      step(1);
      n += chipSelectRise;
    end
    check(16'(n), 16'h0001);
    chipSelectPin = 1'b0;
    repeat (4) begin
      v = 12'($urandom);
      drive(v);
      check(syncPins, v);
    end
    drive(12'hFFF);
    levelClear = 8'hFF;
    step(1);
    levelClear = 8'h00;
    step(1);
    check(levelLatched, 16'h0000);
    drive(12'hFFE);
    drive(12'hFFF);
    check(levelLatched, 16'h0001);
    levelClear = 8'h01;
    step(1);
    levelClear = 8'h00;
    step(1);
    check(levelLatched, 16'h0000);
    // Edge totals: timer one on a muxed pin, timer two always on pin 4.
    for (s = 0; s < 4; s++) begin
      e = s % 3 + 1;
      drive(12'h000);
      tmrMode = 8'h00;
      tmr1PinSel = 2'(s);
      tmrEdgeSel = {2'b01, 2'(e)};
      step(2);
      tmrMode = {`MODE_TOTALCOUNT, `MODE_TOTALCOUNT};
      step(2);
      repeat (3) begin
        drive((12'h010 << s) | 12'h010);
        drive(12'h000);
      end
      rdLatch(1'b0, r);
      check(r, (e == 3) ? 16'h0006 : 16'h0003);
      rdLatch(1'b1, r);
      check(r, 16'h0003);
    end
    // Quadrature on pins 5:4, random steps up then down, signed result.
    tmrMode = {`MODE_IDLE, `MODE_QUAD};
    step(2);
    n = $urandom % 6;
    m = $urandom % 10;
    p = 0;
    for (i = 0; i < n + m; i++) begin
      p = (i < n) ? p + 1 : p - 1;
      drive(12'((((p & 3) ^ ((p & 3) >> 1))) << 4));
    end
    rdLatch(1'b0, r);
    check(r, 16'(n - m));
    // Triggered count on timer one and edge divider on timer two, both on pin 4.
    tmrMode = {`MODE_EDGEDIV, `MODE_TRIGCOUNT};
    tmr1PinSel = 2'h0;
    tmrEdgeSel = 4'h5;
    step(2);
    wr16(1'b1, 16'h0002);
    wr16(1'b0, 16'h0005);
    for (i = 0; i < 6; i++) begin
      check(tmrOut[0], 16'(i < 5));
      drive(12'h010);
      drive(12'h000);
      check(tmrOut[1], 16'(((i + 1) / 2) % 2));
    end
    tmrMode = {`MODE_IDLE, `MODE_ONESHOT};
    step(2);
    ld = {8'h01, 8'($urandom)};
    wr16(1'b0, ld);
    n = 0;
    for (i = 0; i < 12000 && (n == 0 || tmrOut[0] === 1'b1); i++) begin
      n += tmrOut[0];
      step(1);
    end
    check(16'(n >= (ld - 1) * T && n <= (ld + 1) * T), 16'h0001);
    // Full then zero duty on timer one, fastest then stopped square wave on two.
    tmrMode = {`MODE_FREQ, `MODE_PWM};
    step(2);
    for (k = 0; k < 2; k++) begin
      wr16(1'b0, k ? 16'h0000 : 16'h0100);
      wr16(1'b1, k ? 16'h0000 : 16'h0001);
      step(T * 4);
      n = 0;
      m = 0;
      p = tmrOut[1];
      repeat (W) begin
        n += tmrOut[0];
        m += (tmrOut[1] != p);
        p = tmrOut[1];
        step(1);
      end
      check(16'(n), 16'(k ? 0 : W));
      check(16'(m >= (k ? 0 : W / T - 1) && m <= (k ? 0 : W / T + 1)), 16'h0001);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
